// [rtl/i2c_ctrl_pkg.sv]
// Constants and types shared by the two-wire bus controller.
package i2c_ctrl_pkg;

   // ********************************************************************
   // Register map (byte addresses) and reset values
   // ********************************************************************
   localparam logic [7:0] ADDR_DIVIDER = 8'hB8;
   localparam logic [7:0] ADDR_CONTROL = 8'hBC;
   localparam logic [7:0] ADDR_DATA = 8'hC0;
   localparam logic [7:0] ADDR_OWN = 8'hC4;
   localparam logic [7:0] ADDR_STATUS = 8'hC8;
   localparam logic [7:0] RST_DATA = 8'hFF;
   localparam logic [7:0] RST_OWN = 8'hFE;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ********************************************************************
   // Field positions
   // ********************************************************************
   localparam int CTL_DONE = 7;
   localparam int CTL_ACK = 6;
   localparam int CTL_STA = 5;
   localparam int CTL_STO = 4;
   localparam int CTL_EN = 2;
   localparam int CTL_IE = 0;
   localparam int PS_MSB = 1;
   localparam int PS_LSB = 0;
   localparam int GCE_BIT = 0;
   localparam int HTRANS_ACTIVE = 1;
   localparam logic [6:0] GENERAL_CALL = 7'h00;

   // ********************************************************************
   // Bit timing
   // ********************************************************************
   localparam int CNT_W = 15;
   localparam logic [CNT_W-1:0] HALF_BASE = 15'h0008;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // ********************************************************************
   // Status codes
   // ********************************************************************
   localparam logic [7:0] ST_START = 8'h08;
   localparam logic [7:0] ST_REP_START = 8'h10;
   localparam logic [7:0] ST_MT_SLA_ACK = 8'h18;
   localparam logic [7:0] ST_MT_SLA_NACK = 8'h20;
   localparam logic [7:0] ST_MT_DATA_ACK = 8'h28;
   localparam logic [7:0] ST_MT_DATA_NACK = 8'h30;
   localparam logic [7:0] ST_ARB_LOST = 8'h38;
   localparam logic [7:0] ST_MR_SLA_ACK = 8'h40;
   localparam logic [7:0] ST_MR_SLA_NACK = 8'h48;
   localparam logic [7:0] ST_MR_DATA_ACK = 8'h50;
   localparam logic [7:0] ST_MR_DATA_NACK = 8'h58;
   localparam logic [7:0] ST_SR_SLA = 8'h60;
   localparam logic [7:0] ST_SR_SLA_ARB = 8'h68;
   localparam logic [7:0] ST_SR_GC = 8'h70;
   localparam logic [7:0] ST_SR_GC_ARB = 8'h78;
   localparam logic [7:0] ST_SR_DATA_ACK = 8'h80;
   localparam logic [7:0] ST_SR_DATA_NACK = 8'h88;
   localparam logic [7:0] ST_SR_GCD_ACK = 8'h90;
   localparam logic [7:0] ST_SR_GCD_NACK = 8'h98;
   localparam logic [7:0] ST_ST_SLA = 8'hA8;
   localparam logic [7:0] ST_ST_SLA_ARB = 8'hB0;
   localparam logic [7:0] ST_ST_DATA_ACK = 8'hB8;
   localparam logic [7:0] ST_ST_DATA_NACK = 8'hC0;
   localparam logic [7:0] ST_NONE = 8'hF8;

   typedef enum logic [1:0] {ROLE_IDLE, ROLE_MASTER, ROLE_SLAVE} role_t;
   typedef enum logic [2:0] {
      MP_IDLE, MP_START, MP_RS_LOW, MP_RS_HIGH, MP_STOP_LOW,
      MP_STOP_HIGH, MP_BYTE
   } mphase_t;

endpackage : i2c_ctrl_pkg

// [rtl/i2c_arbitration_control.sv]
// Two-wire bus master/slave controller with an AHB-Lite register port.
//
// How it works
// - Direction change uses repeated START, keeps bus.
// - Driving one while seeing zero: lose, release.
// - Lost in address: become slave, compare address.
// - Lost, unaddressed: idle slave or retry START.
// - Identical contending transfers flag no loss.
// - Eight-bit divider sets master bus clock.
// - Job-done flag set on completion; interrupt.
// - Job-done flag holds clock line low unless set by arbitration loss or refused slave byte.
// - Writing one clears flag, as does an unmatched address after a START seen as slave; resumes bus.
// - Acknowledge enable makes address/data acknowledges.
// - Acknowledge enable cleared ignores own address.
// - START request waits for free bus.
// - STOP request as master sends STOP, self-clears.
// - STOP request as slave releases lines, recovers.
// - Data write without flag sets collision flag.
// - Enable bit owns pins; clearing aborts transfer.
// - Control bit one reads zero.
// - Interrupt request high while flag and enables.
// - Prescaler scales divider term by 1, 4, 16, 64.
// - Own-address LSB enables general call recognition.
`timescale 1ns/1ps

module i2c_arbitration_control
   import i2c_ctrl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic global_irq_enable,
   output logic irq
);

   // ********************************************************************
   // State
   // ********************************************************************
   typedef struct packed {
      role_t role;
      mphase_t mph;
      logic [CNT_W-1:0] cnt;
      logic scl_oe, sda_oe, scl_q, sda_q, busy;
      logic [7:0] divider, data, own_addr, shreg, status, rdata;
      logic [1:0] presc;
      logic done, ack_en, sta, sto, wc, en, ie;
      logic active, tx, is_addr, rd_dir, arb_lost, gc, rep, ackbit;
      logic [3:0] bitcnt;
      logic dp_wr;
      logic [7:0] dp_addr;
   } state_t;

   state_t s, n;
   logic rise, fall, start_det, stop_det, go, ack, addr_hit, tick;
   logic [CNT_W-1:0] half;

   // ********************************************************************
   // Functions
   // ********************************************************************
   // The prescaler multiplies the divider by 4 to the power of its code.
   function automatic logic [CNT_W-1:0] half_period(input logic [7:0] d,
                                                    input logic [1:0] p);
      return HALF_BASE + ({7'h00, d} << {p, 1'b0});
   endfunction : half_period

   function automatic logic [7:0] byte_status(input logic master,
      input logic addr, input logic rd, input logic tx, input logic gc,
      input logic arb, input logic ok);
      if (master) begin
         if (addr) begin
            if (rd)
               return ok ? ST_MR_SLA_ACK : ST_MR_SLA_NACK;
            return ok ? ST_MT_SLA_ACK : ST_MT_SLA_NACK;
         end
         if (tx)
            return ok ? ST_MT_DATA_ACK : ST_MT_DATA_NACK;
         return ok ? ST_MR_DATA_ACK : ST_MR_DATA_NACK;
      end
      if (addr) begin
         if (rd)
            return arb ? ST_ST_SLA_ARB : ST_ST_SLA;
         if (gc)
            return arb ? ST_SR_GC_ARB : ST_SR_GC;
         return arb ? ST_SR_SLA_ARB : ST_SR_SLA;
      end
      if (tx)
         return ok ? ST_ST_DATA_ACK : ST_ST_DATA_NACK;
      if (gc)
         return ok ? ST_SR_GCD_ACK : ST_SR_GCD_NACK;
      return ok ? ST_SR_DATA_ACK : ST_SR_DATA_NACK;
   endfunction : byte_status

   function automatic logic [7:0] read_reg(input logic [7:0] a,
                                           input state_t v);
      logic [7:0] r;
      r = READ_ZERO;
      case (a)
         ADDR_DIVIDER: r = v.divider;
         ADDR_CONTROL: r = {v.done, v.ack_en, v.sta, v.sto, v.wc, v.en,
                            1'b0, v.ie};
         ADDR_DATA: r = v.data;
         ADDR_OWN: r = v.own_addr;
         ADDR_STATUS: r = {v.done ? v.status[7:3] : ST_NONE[7:3], 1'b0,
                           v.presc};
         default: r = READ_ZERO;
      endcase
      return r;
   endfunction : read_reg

   // ********************************************************************
   // Next state
   // ********************************************************************
   always_comb begin
      n = s;
      rise = ~s.scl_q & scl_in;
      fall = s.scl_q & ~scl_in;
      start_det = s.scl_q & scl_in & s.sda_q & ~sda_in;
      stop_det = s.scl_q & scl_in & ~s.sda_q & sda_in;
      half = half_period(s.divider, s.presc);
      tick = (s.cnt >= half);
      ack = ~s.ackbit;
      addr_hit = 1'b0;
      go = 1'b0;
      n.scl_q = scl_in;
      n.sda_q = sda_in;

      if (s.dp_wr) begin
         case (s.dp_addr)
            ADDR_DIVIDER: n.divider = hwdata[7:0];
            ADDR_CONTROL: begin
               go = hwdata[CTL_DONE] & s.done;
               n.ack_en = hwdata[CTL_ACK];
               n.sta = hwdata[CTL_STA];
               n.sto = hwdata[CTL_STO];
               n.en = hwdata[CTL_EN];
               n.ie = hwdata[CTL_IE];
            end
            ADDR_DATA: begin
               if (s.done) begin
                  n.data = hwdata[7:0];
                  n.wc = 1'b0;
               end else begin
                  n.wc = 1'b1;
               end
            end
            ADDR_OWN: n.own_addr = hwdata[7:0];
            ADDR_STATUS: n.presc = hwdata[PS_MSB:PS_LSB];
            default: ;
         endcase
      end
      if (go)
         n.done = 1'b0;
      if (start_det)
         n.busy = 1'b1;
      if (stop_det)
         n.busy = 1'b0;
      // A START seen while enabled and not master restarts address reception.
      if (start_det && s.role != ROLE_MASTER && s.en) begin
         n.role = ROLE_SLAVE;
         n.active = 1'b1;
         n.bitcnt = '0;
         n.tx = 1'b0;
         n.is_addr = 1'b1;
         n.arb_lost = 1'b0;
         n.sda_oe = 1'b0;
         n.scl_oe = 1'b0;
      end else if (stop_det && s.role == ROLE_SLAVE) begin
         n.role = ROLE_IDLE;
         n.active = 1'b0;
         n.sda_oe = 1'b0;
      end
      if (go) begin
         if (n.sto && s.role != ROLE_MASTER) begin
            n.sto = 1'b0;
            n.role = ROLE_IDLE;
            n.active = 1'b0;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
         end else if (s.role == ROLE_MASTER && n.sta) begin
            n.mph = MP_RS_LOW;
            n.sda_oe = 1'b0;
            n.cnt = '0;
         end else if (s.role == ROLE_MASTER && n.sto) begin
            n.mph = MP_STOP_LOW;
            n.sda_oe = 1'b1;
            n.cnt = '0;
         end else if (s.role != ROLE_IDLE) begin
            n.active = 1'b1;
            n.bitcnt = '0;
            n.cnt = '0;
            n.tx = (s.role == ROLE_MASTER) ? (s.is_addr | ~s.rd_dir)
                                           : s.rd_dir;
            if (s.role == ROLE_MASTER && s.is_addr)
               n.rd_dir = s.data[0];
            n.shreg = n.tx ? s.data : BYTE_ONES;
            n.sda_oe = n.tx & ~s.data[7];
            n.scl_oe = (s.role == ROLE_MASTER);
         end
      end
      // The bus must be seen free, so a START never cuts into a frame.
      if (s.role == ROLE_IDLE && !start_det && s.sta && s.en && !s.busy &&
          !s.done) begin
         n.role = ROLE_MASTER;
         n.mph = MP_START;
         n.sda_oe = 1'b1;
         n.cnt = '0;
         n.rep = 1'b0;
      end

      // ********************************************************************
      // Master clock and condition generation
      // ********************************************************************
      if (s.role == ROLE_MASTER && !s.done) begin
         case (s.mph)
            MP_START: begin
               n.cnt = s.cnt + 1'b1;
               if (tick) begin
                  n.scl_oe = 1'b1;
                  n.done = 1'b1;
                  n.status = s.rep ? ST_REP_START : ST_START;
                  n.is_addr = 1'b1;
                  n.mph = MP_BYTE;
                  n.cnt = '0;
                  n.rep = 1'b0;
               end
            end
            MP_RS_LOW: begin
               n.cnt = s.cnt + 1'b1;
               if (tick) begin
                  n.scl_oe = 1'b0;
                  n.cnt = '0;
                  n.mph = MP_RS_HIGH;
               end
            end
            MP_RS_HIGH: begin
               if (scl_in)
                  n.cnt = s.cnt + 1'b1;
               if (scl_in && tick) begin
                  n.sda_oe = 1'b1;
                  n.cnt = '0;
                  n.rep = 1'b1;
                  n.mph = MP_START;
               end
            end
            MP_STOP_LOW: begin
               n.cnt = s.cnt + 1'b1;
               if (tick) begin
                  n.scl_oe = 1'b0;
                  n.cnt = '0;
                  n.mph = MP_STOP_HIGH;
               end
            end
            MP_STOP_HIGH: begin
               if (scl_in)
                  n.cnt = s.cnt + 1'b1;
               if (scl_in && tick) begin
                  n.sda_oe = 1'b0;
                  n.sto = 1'b0;
                  n.role = ROLE_IDLE;
                  n.mph = MP_IDLE;
               end
            end
            MP_BYTE: begin
               // Counting the high half only once the line reads high
               // lets a slow slave stretch the clock.
               if (s.active && (s.scl_oe || scl_in)) begin
                  n.cnt = s.cnt + 1'b1;
                  if (tick) begin
                     n.scl_oe = ~s.scl_oe;
                     n.cnt = '0;
                  end
               end
            end
            default: ;
         endcase
      end

      // ********************************************************************
      // Bit engine, shared by master and slave
      // ********************************************************************
      if (s.active && rise) begin
         // Equal bits on the wire never trip this, so identical
         // transfers from several masters pass unnoticed.
         if (s.role == ROLE_MASTER && s.tx && s.bitcnt < BITS_PER_BYTE &&
             !s.sda_oe && !sda_in) begin
            n.mph = MP_IDLE;
            n.scl_oe = 1'b0;
            n.arb_lost = 1'b1;
            if (s.is_addr) begin
               n.role = ROLE_SLAVE;
               n.tx = 1'b0;
            end else begin
               n.role = ROLE_IDLE;
               n.active = 1'b0;
               n.done = 1'b1;
               n.status = ST_ARB_LOST;
            end
         end
         if (s.bitcnt < BITS_PER_BYTE)
            n.shreg = {s.shreg[6:0], sda_in};
         else
            n.ackbit = sda_in;
         n.bitcnt = s.bitcnt + 1'b1;
      end
      if (s.active && fall && n.active) begin
         if (s.bitcnt < BITS_PER_BYTE) begin
            n.sda_oe = s.tx & ~s.shreg[7];
         end else if (s.bitcnt == BITS_PER_BYTE) begin
            if (s.role == ROLE_SLAVE && s.is_addr) begin
               n.gc = (s.shreg[7:1] == GENERAL_CALL);
               addr_hit = s.ack_en & ((s.shreg[7:1] == s.own_addr[7:1]) |
                  (s.own_addr[GCE_BIT] & n.gc));
               n.rd_dir = s.shreg[0];
               n.sda_oe = addr_hit;
               if (!addr_hit) begin
                  n.role = ROLE_IDLE;
                  n.active = 1'b0;
                  n.done = s.arb_lost;
                  n.status = ST_ARB_LOST;
               end
            end else begin
               n.sda_oe = ~s.tx & s.ack_en;
            end
         end else begin
            n.active = 1'b0;
            n.done = 1'b1;
            n.sda_oe = 1'b0;
            n.is_addr = 1'b0;
            n.status = byte_status(s.role == ROLE_MASTER, s.is_addr,
                                   s.rd_dir, s.tx, s.gc, s.arb_lost, ack);
            if (!s.tx)
               n.data = s.shreg;
            // A refused byte ends the slave's part in the frame.
            if (s.role == ROLE_SLAVE && !s.is_addr && !ack)
               n.role = ROLE_IDLE;
            else
               n.scl_oe = 1'b1;
         end
      end
      if (!n.en) begin
         n.role = ROLE_IDLE;
         n.mph = MP_IDLE;
         n.active = 1'b0;
         n.scl_oe = 1'b0;
         n.sda_oe = 1'b0;
      end
      n.dp_wr = hsel & hready & htrans[HTRANS_ACTIVE] & hwrite;
      n.dp_addr = haddr;
      // Reading the next state makes a read right after a write current.
      if (hsel && hready && htrans[HTRANS_ACTIVE] && !hwrite)
         n.rdata = read_reg(haddr, n);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.data <= RST_DATA;
         s.own_addr <= RST_OWN;
         s.status <= ST_NONE;
         s.scl_q <= 1'b1;
         s.sda_q <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   assign hrdata = {24'h000000, s.rdata};
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = s.scl_oe;
   assign sda_oe = s.sda_oe;
   assign irq = s.done & s.ie & global_irq_enable;

endmodule : i2c_arbitration_control

// [sim/i2c_arbitration_control_sva.sv]
// Port-level assertion checker for the two-wire bus controller.
`timescale 1ns/1ps

module i2c_arbitration_control_sva
   import i2c_ctrl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic global_irq_enable,
   input wire logic irq
);
   logic take;
   logic rd_ctl;
   logic wr_ctl;
   assign take = hsel && hready && htrans[HTRANS_ACTIVE];
   assign rd_ctl = take && !hwrite && haddr == ADDR_CONTROL;
   assign wr_ctl = take && hwrite && haddr == ADDR_CONTROL;
   // Read data and irq both show the state taken at the read's edge.
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_irq_gated: assert property (irq |-> global_irq_enable)
      else $error("irq high while global enable low");
   chk_irq_flag_match: assert property (rd_ctl |=>
      (hrdata[CTL_DONE] & hrdata[CTL_IE] & global_irq_enable)
      == irq) else $error("irq differs from flag and enables");
   chk_bit1_zero: assert property (rd_ctl |=> !hrdata[1])
      else $error("reserved control bit reads one");
   chk_upper_zero: assert property (take && !hwrite |=>
      hrdata[31:8] == 24'h000000) else $error("upper read bits set");
   chk_reset_quiet: assert property ($rose(hresetn) |->
      !scl_oe && !sda_oe && !irq) else $error("lines driven after reset");
   chk_stretch_hold: assert property (irq && scl_oe |=>
      scl_oe || !irq) else $error("clock released while flag set");
   chk_enable_off: assert property (wr_ctl ##1 !hwdata[CTL_EN] |->
      ##[1:2] (!scl_oe && !sda_oe)) else $error("lines held after off");
   chk_open_drain: assert property (!scl_out && !sda_out)
      else $error("line driven high");
endmodule : i2c_arbitration_control_sva

bind i2c_arbitration_control i2c_arbitration_control_sva
   i2c_arbitration_control_sva_inst (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .scl_out(scl_out),
   .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
   .global_irq_enable(global_irq_enable), .irq(irq));

// [sim/i2c_slave_model.sv]
// Behavioural slave device on the two-wire bus, the far-side partner.
`timescale 1ns/1ps

module i2c_slave_model #(
   parameter logic [6:0] SLAVE_ADDR = 7'h2A,
   parameter logic [7:0] TX_BYTE = 8'hA5
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic stretch,
   output logic scl_pull,
   output logic sda_pull,
   output logic [7:0] last_rx
);
   int bit_cnt;
   logic [7:0] sh;
   logic active;
   logic is_addr;
   logic rd_mode;
   logic acked;
   logic sending;
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      last_rx = 8'h00;
      active = 1'b0;
      sending = 1'b0;
   end
   // A data fall with the clock high opens a frame, a rise closes it.
   always @(negedge sda) begin
      if (scl) begin
         active = 1'b1;
         is_addr = 1'b1;
         rd_mode = 1'b0;
         sending = 1'b0;
         bit_cnt = 0;
      end
   end
   always @(posedge sda) begin
      if (scl) begin
         active = 1'b0;
      end
   end
   always @(posedge scl) begin
      if (active && bit_cnt < 8) begin
         sh = {sh[6:0], sda};
         bit_cnt++;
      end else if (active && rd_mode && !is_addr) begin
         acked = !sda;
      end
   end
   // Lines change only while the clock is low, so no false frame marks.
   always @(negedge scl) begin
      if (active && bit_cnt == 9) begin
         bit_cnt = 0;
         is_addr = 1'b0;
         sending = rd_mode && acked;
         sda_pull = sending && !TX_BYTE[7];
         if (stretch && acked) begin
            scl_pull = 1'b1;
            #200;
            scl_pull = 1'b0;
         end
      end else if (active && bit_cnt == 8) begin
         bit_cnt = 9;
         if (is_addr) begin
            rd_mode = sh[0];
            acked = sh[7:1] == SLAVE_ADDR;
         end else if (!rd_mode) begin
            last_rx = sh;
         end
         sda_pull = acked && (is_addr || !rd_mode);
      end else if (active) begin
         sda_pull = sending && !TX_BYTE[7 - bit_cnt];
      end
   end
endmodule : i2c_slave_model

// [sim/tb.sv]
// Self-checking testbench for the two-wire bus controller.
`timescale 1ns/1ps

module tb
   import i2c_ctrl_pkg::*;
();
   typedef struct {logic [7:0] a; logic w; logic [7:0] d;} row_t;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic scl_oe;
   logic sda_oe;
   logic gie;
   logic irq;
   logic m_scl;
   logic m_sda;
   logic bb_scl;
   logic bb_sda;
   logic stretch;
   logic ack;
   logic [7:0] rx;
   logic [7:0] r;
   int n_mismatch;
   int n_compared;
   row_t rows [17];
   wire scl_w = !(scl_oe | m_scl | bb_scl);
   wire sda_w = !(sda_oe | m_sda | bb_sda);
   i2c_arbitration_control i2c_arbitration_control_inst (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .scl_in(scl_w),
      .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(),
      .sda_oe(sda_oe), .global_irq_enable(gie), .irq(irq));
   i2c_slave_model i2c_slave_model_inst (.scl(scl_w), .sda(sda_w),
      .stretch(stretch), .scl_pull(m_scl), .sda_pull(m_sda), .last_rx(rx));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // ****************
   // Tasks
   // ****************
   task automatic check(input string nm, input logic [7:0] s, e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata[7:0];
   endtask : bus
   task automatic rd_chk(input string nm, input logic [7:0] a, e);
      bus(a, 1'b0, 8'h00);
      check(nm, r, e);
   endtask : rd_chk
   // Software polls the flag and reads status before any clear.
   task automatic wait_done(input logic [7:0] st);
      int k;
      k = 0;
      r = 8'h00;
      while (r[CTL_DONE] !== 1'b1 && k < 400) begin
         bus(ADDR_CONTROL, 1'b0, 8'h00);
         k++;
      end
      rd_chk("status", ADDR_STATUS, st);
   endtask : wait_done
   task automatic bb_start();
      bb_sda <= 1'b1;
      cyc(10);
      bb_scl <= 1'b1;
      cyc(10);
   endtask : bb_start
   task automatic bb_stop();
      bb_scl <= 1'b1;
      cyc(10);
      bb_sda <= 1'b1;
      cyc(10);
      bb_scl <= 1'b0;
      cyc(10);
      bb_sda <= 1'b0;
      cyc(10);
   endtask : bb_stop
   task automatic bb_byte(input logic [7:0] b);
      for (int i = 7; i >= -1; i--) begin
         bb_sda <= (i >= 0) && !b[i];
         cyc(10);
         bb_scl <= 1'b0;
         cyc(10);
         ack = !sda_w;
         bb_scl <= 1'b1;
      end
   endtask : bb_byte
   task automatic report_and_stop();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   // ****************
   // Sequence
   // ****************
   initial begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
      {gie, bb_scl, bb_sda, stretch, n_mismatch, n_compared} = '0;
      hsize = 3'h2;
      rows = '{'{ADDR_DIVIDER, 0, 8'h00}, '{ADDR_CONTROL, 0, 8'h00},
         '{ADDR_DIVIDER, 1, 8'h5A}, '{ADDR_DIVIDER, 0, 8'h5A},
         '{ADDR_CONTROL, 1, 8'h43}, '{ADDR_CONTROL, 0, 8'h41},
         '{ADDR_DATA, 1, 8'h55}, '{ADDR_CONTROL, 0, 8'h49},
         '{ADDR_DATA, 0, 8'hFF}, '{8'hF0, 1, 8'h77}, '{8'hF0, 0, 8'h00},
         '{ADDR_STATUS, 0, ST_NONE}, '{ADDR_DIVIDER, 1, 8'h00},
         '{ADDR_STATUS, 1, 8'h03}, '{ADDR_STATUS, 0, 8'hFB},
         '{ADDR_STATUS, 1, 8'h00},
         '{ADDR_OWN, 1, 8'h66}};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      cyc(1);
      foreach (rows[i]) begin
         if (rows[i].w) begin
            bus(rows[i].a, 1'b1, rows[i].d);
         end else begin
            rd_chk("table", rows[i].a, rows[i].d);
         end
      end
      bus(ADDR_CONTROL, 1'b1, 8'h44);
      bb_start();
      bb_byte(8'h66);
      check("own address ack", {7'h0, ack}, 8'h01);
      wait_done(ST_SR_SLA);
      bb_scl <= 1'b0;
      cyc(20);
      check("slave stretch", {7'h0, scl_w}, 8'h00);
      bus(ADDR_CONTROL, 1'b1, 8'hD4);
      cyc(10);
      check("lines free", {6'h0, scl_w, sda_w}, 8'h03);
      rd_chk("stop cleared", ADDR_CONTROL, 8'h4C);
      bb_stop();
      bus(ADDR_CONTROL, 1'b1, 8'h04);
      bb_start();
      bb_byte(8'h66);
      check("ack when off", {7'h0, ack}, 8'h00);
      bus(ADDR_CONTROL, 1'b1, 8'h24);
      cyc(100);
      check("start held off", {7'h0, sda_oe}, 8'h00);
      bb_stop();
      wait_done(ST_START);
      gie <= 1'b1;
      bus(ADDR_CONTROL, 1'b1, 8'h45);
      rd_chk("flag kept", ADDR_CONTROL, 8'hCD);
      check("irq on", {7'h0, irq}, 8'h01);
      bus(ADDR_DATA, 1'b1, 8'h54);
      rd_chk("collision cleared", ADDR_CONTROL, 8'hC5);
      bus(ADDR_CONTROL, 1'b1, 8'hC5);
      wait_done(ST_MT_SLA_ACK);
      bus(ADDR_DATA, 1'b1, 8'h3C);
      bus(ADDR_CONTROL, 1'b1, 8'hC5);
      wait_done(ST_MT_DATA_ACK);
      check("slave byte", rx, 8'h3C);
      bus(ADDR_CONTROL, 1'b1, 8'hE5);
      wait_done(ST_REP_START);
      stretch <= 1'b1;
      bus(ADDR_DATA, 1'b1, 8'h55);
      bus(ADDR_CONTROL, 1'b1, 8'hC5);
      wait_done(ST_MR_SLA_ACK);
      bus(ADDR_CONTROL, 1'b1, 8'hC5);
      wait_done(ST_MR_DATA_ACK);
      rd_chk("read byte", ADDR_DATA, 8'hA5);
      bus(ADDR_CONTROL, 1'b1, 8'h85);
      wait_done(ST_MR_DATA_NACK);
      bus(ADDR_CONTROL, 1'b1, 8'h95);
      cyc(60);
      rd_chk("stop done", ADDR_CONTROL, 8'h05);
      check("irq off", {7'h0, irq}, 8'h00);
      check("bus free", {6'h0, scl_w, sda_w}, 8'h03);
      bus(ADDR_CONTROL, 1'b1, 8'h00);
      report_and_stop();
   end
   // The whole run needs well under ten thousand cycles.
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end
endmodule : tb
